// file: ipl_arb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipl_map.svh"
module ipl_arb
  import ipl_pkg::*;
#(
  parameter int SRC_N = `IPL_SRC_N
)
(
  // pending requests and their levels
  input wire logic [SRC_N-1:0] pend,
  input wire logic [SRC_N-1:0] high,
  // winner
  output var ipl_grant_t grant
);
  always_comb
  begin
    grant = '0;
    // scan downward so the smallest index is the last to win
    for (int i = SRC_N - 1; i >= 0; i--)
    begin
      if (pend[i] && !high[i])
        grant = '{valid: 1'b1, level: 1'b0, index: `IPL_IDX_W'(i)};
    end
    // a level 1 request overrides any level 0 pick
    for (int i = SRC_N - 1; i >= 0; i--)
    begin
      if (pend[i] && high[i])
        grant = '{valid: 1'b1, level: 1'b1, index: `IPL_IDX_W'(i)};
    end
  end
endmodule // ipl_arb
`default_nettype wire

// file: ipl_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipl_map.svh"
// ****************************
// cpu core side: takes the presented request at every edge
// ****************************
module ipl_cpu_model
  import ipl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // presented request
  input wire logic req_valid,
  input wire logic req_level,
  input wire logic [`IPL_IDX_W-1:0] req_index,
  // last request taken, one edge behind the port
  output var ipl_grant_t taken
);
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      taken <= 8'h00;
    else
      taken <= {req_valid, req_level, req_index};
endmodule // ipl_cpu_model
`default_nettype wire

// file: ipl_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipl_map.svh"
module ipl_ctrl
  import ipl_pkg::*;
#(
  parameter int SRC_N = `IPL_SRC_N
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // hardware standby, synchronous level
  input wire logic hw_standby,
  // axi4-lite write address and data
  input wire logic [`IPL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`IPL_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pending, enabled requests, ascending vector order
  input wire logic [SRC_N-1:0] src_req,
  // request presented to the cpu core
  output logic cpu_req_valid,
  output logic cpu_req_level,
  output logic [`IPL_IDX_W-1:0] cpu_req_index
);
  // ****************************
  // state
  // ****************************
  logic [7:0] sel_a_r;
  logic [7:0] sel_b_r;
  logic [`IPL_ADDR_W-1:0] waddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  ipl_grant_t grant_r;

  // ****************************
  // write channel decode
  // ****************************
  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire have_aw = aw_hold_r || aw_take;
  wire have_w = w_hold_r || w_take;
  wire [`IPL_ADDR_W-1:0] cur_waddr = aw_hold_r ? waddr_r : s_axi_awaddr;
  wire [7:0] cur_wdata = w_hold_r ? wdata_r : s_axi_wdata[7:0];
  wire cur_strb0 = w_hold_r ? wstrb0_r : s_axi_wstrb[0];
  // the response waits for the previous one to be taken
  wire wr_commit = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_hit_a = waddr_r == `IPL_OFF_SEL_A;
  wire wr_hit_b = waddr_r == `IPL_OFF_SEL_B;
  wire wr_hit_st = waddr_r == `IPL_OFF_STATUS;
  wire wr_mapped = wr_hit_a || wr_hit_b || wr_hit_st;
  wire b_done = bvalid_r && s_axi_bready;

  // only byte lane 0 carries data; other lanes are ignored
  wire wr_a = wr_commit && wr_hit_a && wstrb0_r;
  wire wr_b = wr_commit && wr_hit_b && wstrb0_r;
  wire [7:0] sel_a_nxt = hw_standby ? `IPL_SEL_RST : (wr_a ? wdata_r : sel_a_r);
  wire [7:0] sel_b_nxt = hw_standby ? `IPL_SEL_RST : (wr_b ? wdata_r : sel_b_r);

  // ****************************
  // read channel decode
  // ****************************
  wire ar_take = s_axi_arvalid && arready_r;
  wire r_done = rvalid_r && s_axi_rready;
  wire rd_hit_a = s_axi_araddr == `IPL_OFF_SEL_A;
  wire rd_hit_b = s_axi_araddr == `IPL_OFF_SEL_B;
  wire rd_hit_st = s_axi_araddr == `IPL_OFF_STATUS;
  wire [7:0] status_byte = {grant_r.valid, grant_r.level, grant_r.index};
  wire [7:0] rd_byte = rd_hit_a ? sel_a_r
    : (rd_hit_b ? sel_b_r : (rd_hit_st ? status_byte : 8'h00));
  wire [1:0] rd_resp = (rd_hit_a || rd_hit_b || rd_hit_st) ? `IPL_RESP_OKAY : `IPL_RESP_SLVERR;

  // ****************************
  // level per source and arbitration
  // ****************************
  wire [SRC_N-1:0] src_high;
  ipl_grant_t grant_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < SRC_N; gi++)
    begin : g_level
      // level 0 when the bit is clear, level 1 when set
      assign src_high[gi] = ipl_level_of(ipl_group_of(gi), sel_a_r, sel_b_r);
    end
  endgenerate

  // levels come from the stored registers, so a write acts one edge later
  ipl_arb #(.SRC_N(SRC_N)) u_arb (
    .pend(src_req),
    .high(src_high),
    .grant(grant_nxt)
  );

  // ****************************
  // registers
  // ****************************
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_a_r <= `IPL_SEL_RST;
      sel_b_r <= `IPL_SEL_RST;
    end
    else
    begin
      sel_a_r <= sel_a_nxt;
      sel_b_r <= sel_b_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      waddr_r <= '0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end
    else
    begin
      aw_hold_r <= have_aw && !wr_commit;
      w_hold_r <= have_w && !wr_commit;
      awready_r <= !have_aw || wr_commit;
      wready_r <= !have_w || wr_commit;
      waddr_r <= cur_waddr;
      wdata_r <= cur_wdata;
      wstrb0_r <= cur_strb0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `IPL_RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? `IPL_RESP_OKAY : `IPL_RESP_SLVERR;
    end
    else if (b_done)
    begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `IPL_RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= rd_resp;
    end
    else if (r_done)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // the presented request is registered; request inputs are never written back
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      grant_r <= '0;
    else
      grant_r <= grant_nxt;
  end

  // ****************************
  // outputs
  // ****************************
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign cpu_req_valid = grant_r.valid;
  assign cpu_req_level = grant_r.level;
  assign cpu_req_index = grant_r.index;

  // ****************************
  // checks
  // ****************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_standby_clears: assert property (hw_standby
    |=> sel_a_r == 8'h00 && sel_b_r == 8'h00)
    else $error("standby did not clear the priority registers");
  a_b_full_byte: assert property (wr_b && !hw_standby |=> sel_b_r == $past(wdata_r))
    else $error("second register did not store the written byte");
  a_reserved_inert: assert property (wr_b && !hw_standby
    && (wdata_r & 8'hcc) == (sel_b_r & 8'hcc) |=> src_high == $past(src_high))
    else $error("a reserved bit of the second register moved a level");
  // each granted index must carry the level of its own group bit
  a_pin0_level: assert property (grant_nxt.valid && grant_nxt.index == 6'h00
    |=> cpu_req_level == $past(sel_a_r[7]))
    else $error("pin 0 level does not follow bit 7");
  a_pin1_level: assert property (grant_nxt.valid && grant_nxt.index == 6'h01
    |=> cpu_req_level == $past(sel_a_r[6]))
    else $error("pin 1 level does not follow bit 6");
  a_pins23_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {6'h02, 6'h03} |=> cpu_req_level == $past(sel_a_r[5]))
    else $error("pins 2 and 3 level does not follow bit 5");
  a_pins45_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {6'h04, 6'h05} |=> cpu_req_level == $past(sel_a_r[4]))
    else $error("pins 4 and 5 level does not follow bit 4");
  a_wdt_level: assert property (grant_nxt.valid && grant_nxt.index == 6'h06
    |=> cpu_req_level == $past(sel_a_r[3]))
    else $error("watchdog level does not follow bit 3");
  a_adc_level: assert property (grant_nxt.valid && grant_nxt.index == 6'h20
    |=> cpu_req_level == $past(sel_a_r[3]))
    else $error("converter level does not follow bit 3");
  a_wt0_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {[6'h07:6'h09]} |=> cpu_req_level == $past(sel_a_r[2]))
    else $error("wide timer 0 level does not follow bit 2");
  a_wt1_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {[6'h0a:6'h0c]} |=> cpu_req_level == $past(sel_a_r[1]))
    else $error("wide timer 1 level does not follow bit 1");
  a_wt2_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {[6'h0d:6'h0f]} |=> cpu_req_level == $past(sel_a_r[0]))
    else $error("wide timer 2 level does not follow bit 0");
  a_nt01_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {[6'h10:6'h13]} |=> cpu_req_level == $past(sel_b_r[7]))
    else $error("narrow timers 0 and 1 level does not follow bit 7");
  a_nt23_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {[6'h14:6'h17]} |=> cpu_req_level == $past(sel_b_r[6]))
    else $error("narrow timers 2 and 3 level does not follow bit 6");
  a_ser0_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {[6'h18:6'h1b]} |=> cpu_req_level == $past(sel_b_r[3]))
    else $error("serial 0 level does not follow bit 3 of the second register");
  a_ser1_level: assert property (grant_nxt.valid
    && grant_nxt.index inside {[6'h1c:6'h1f]} |=> cpu_req_level == $past(sel_b_r[2]))
    else $error("serial 1 level does not follow bit 2 of the second register");
  a_high_first: assert property ((src_req & src_high) != '0
    |=> cpu_req_valid && cpu_req_level)
    else $error("a level 1 request was passed over");
  a_lowest_wins: assert property (cpu_req_valid && cpu_req_index != 6'h00
    |-> ($past(src_req) & ~({SRC_N{1'b1}} << cpu_req_index)
    & ($past(src_high) ^ {SRC_N{!cpu_req_level}})) == '0)
    else $error("a smaller vector at the same level was passed over");
  a_write_answer: assert property (aw_take && w_take && !bvalid_r
    |-> ##2 s_axi_bvalid)
    else $error("write answer not two edges after address and data");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one edge after the address");

  // ****************************
  // main scenarios
  // ****************************
  c_write_a: cover property (wr_a ##1 sel_a_r != 8'h00);
  c_high_grant: cover property (cpu_req_valid && cpu_req_level);
  c_low_grant: cover property (cpu_req_valid && !cpu_req_level && cpu_req_index != 6'h00);
  c_read_status: cover property (ar_take && rd_hit_st);
  c_standby_clear: cover property (hw_standby ##1 sel_a_r == 8'h00);
endmodule // ipl_ctrl
`default_nettype wire

// file: ipl_map.svh
// Operation
// - a cleared priority bit puts its group at level 0, a set bit at level 1
// - both priority registers are 8-bit read/write, cleared to 00 by reset and standby
// - first register bit 7 sets the level of external pin 0 requests
// - first register bit 6 sets the level of external pin 1 requests
// - first register bit 5 sets the level of external pins 2 and 3
// - first register bit 4 sets the level of external pins 4 and 5
// - first register bit 3 sets the level of watchdog and converter requests
// - first register bit 2 sets the level of wide timer channel 0
// - first register bit 1 sets the level of wide timer channel 1
// - first register bit 0 sets the level of wide timer channel 2
// - second register bit 7 sets the level of narrow timer channels 0 and 1
// - second register bit 6 sets the level of narrow timer channels 2 and 3
// - second register bits 5, 4, 1, 0 store and read back, affect nothing
// - second register bit 3 sets the level of serial channel 0
// - second register bit 2 sets the level of serial channel 1
// - within one level the smaller vector number wins
`ifndef IPL_MAP_SVH
`define IPL_MAP_SVH
// ****************************
// register map
// ****************************
`define IPL_ADDR_W 8
`define IPL_OFF_SEL_A 8'h00
`define IPL_OFF_SEL_B 8'h04
`define IPL_OFF_STATUS 8'h08
`define IPL_SEL_RST 8'h00
// ****************************
// field positions
// ****************************
`define IPL_A_PIN0 7
`define IPL_A_PIN1 6
`define IPL_A_PINS23 5
`define IPL_A_PINS45 4
`define IPL_A_WDT_ADC 3
`define IPL_A_WT0 2
`define IPL_A_WT1 1
`define IPL_A_WT2 0
`define IPL_B_NT01 7
`define IPL_B_NT23 6
`define IPL_B_SER0 3
`define IPL_B_SER1 2
`define IPL_ST_VALID 7
`define IPL_ST_LEVEL 6
// ****************************
// sources and bus answers
// ****************************
`define IPL_SRC_N 33
`define IPL_IDX_W 6
`define IPL_RESP_OKAY 2'h0
`define IPL_RESP_SLVERR 2'h2
`endif

// file: ipl_pkg.sv
`default_nettype none
`include "ipl_map.svh"
package ipl_pkg;
  typedef enum logic [3:0] {
    IPL_GRP_PIN0, IPL_GRP_PIN1, IPL_GRP_PINS23, IPL_GRP_PINS45, IPL_GRP_WDT_ADC,
    IPL_GRP_WT0, IPL_GRP_WT1, IPL_GRP_WT2, IPL_GRP_NT01, IPL_GRP_NT23,
    IPL_GRP_SER0, IPL_GRP_SER1
  } ipl_grp_t;

  typedef struct packed {
    logic valid;
    logic level;
    logic [`IPL_IDX_W-1:0] index;
  } ipl_grant_t;

  // sources are numbered in ascending vector order
  function automatic ipl_grp_t ipl_group_of(input int idx);
    ipl_grp_t g;
    g = IPL_GRP_WDT_ADC;
    if (idx == 0)
      g = IPL_GRP_PIN0;
    else if (idx == 1)
      g = IPL_GRP_PIN1;
    else if (idx <= 3)
      g = IPL_GRP_PINS23;
    else if (idx <= 5)
      g = IPL_GRP_PINS45;
    else if (idx == 6)
      g = IPL_GRP_WDT_ADC;
    else if (idx <= 9)
      g = IPL_GRP_WT0;
    else if (idx <= 12)
      g = IPL_GRP_WT1;
    else if (idx <= 15)
      g = IPL_GRP_WT2;
    else if (idx <= 19)
      g = IPL_GRP_NT01;
    else if (idx <= 23)
      g = IPL_GRP_NT23;
    else if (idx <= 27)
      g = IPL_GRP_SER0;
    else if (idx <= 31)
      g = IPL_GRP_SER1;
    return g;
  endfunction

  // reserved bits of the second register are never looked at
  function automatic logic ipl_level_of(input ipl_grp_t g, input logic [7:0] a,
                                        input logic [7:0] b);
    logic lvl;
    lvl = 1'b0;
    unique case (g)
      IPL_GRP_PIN0: lvl = a[`IPL_A_PIN0];
      IPL_GRP_PIN1: lvl = a[`IPL_A_PIN1];
      IPL_GRP_PINS23: lvl = a[`IPL_A_PINS23];
      IPL_GRP_PINS45: lvl = a[`IPL_A_PINS45];
      IPL_GRP_WDT_ADC: lvl = a[`IPL_A_WDT_ADC];
      IPL_GRP_WT0: lvl = a[`IPL_A_WT0];
      IPL_GRP_WT1: lvl = a[`IPL_A_WT1];
      IPL_GRP_WT2: lvl = a[`IPL_A_WT2];
      IPL_GRP_NT01: lvl = b[`IPL_B_NT01];
      IPL_GRP_NT23: lvl = b[`IPL_B_NT23];
      IPL_GRP_SER0: lvl = b[`IPL_B_SER0];
      IPL_GRP_SER1: lvl = b[`IPL_B_SER1];
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction
endpackage
`default_nettype wire

// file: ipl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipl_map.svh"
module testbench
  import ipl_pkg::*;
;
  // ****************************
  // signals
  // ****************************
  logic clock, rstn, hw_standby, awvalid, wvalid, bready, arvalid, rready;
  logic [`IPL_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [32:0] src_req;
  wire logic awready, wready, bvalid, arready, rvalid, vld, lvl;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [`IPL_IDX_W-1:0] idx;
  ipl_grant_t taken;
  int err_count, n_compared, s, o;
  int cycles = 0;
  // one source per group, and its priority bit as {b, a}
  int src_of [12] = '{0, 1, 3, 5, 32, 9, 12, 15, 19, 23, 27, 31};
  logic [15:0] sel_of [12] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
    16'h0004, 16'h0002, 16'h0001, 16'h8000, 16'h4000, 16'h0800, 16'h0400};

  ipl_ctrl dut (.clock(clock), .rstn(rstn), .hw_standby(hw_standby),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_req(src_req), .cpu_req_valid(vld),
    .cpu_req_level(lvl), .cpu_req_index(idx));
  ipl_cpu_model cpu (.clock(clock), .rstn(rstn), .req_valid(vld), .req_level(lvl),
    .req_index(idx), .taken(taken));

  // ****************************
  // tasks
  // ****************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    check(rdata, {24'h000000, ed});
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // ****************************
  // clock, timeout, sequence
  // ****************************
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // the whole run needs well under 3000 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    {rstn, hw_standby, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, src_req} = 81'h0;
    wstrb = 4'hf;
    err_count = 0;
    n_compared = 0;
    idle(5);
    rstn <= 1'b1;
    rd(`IPL_OFF_SEL_A, 8'h00, `IPL_RESP_OKAY);
    rd(`IPL_OFF_SEL_B, 8'h00, `IPL_RESP_OKAY);
    // each group alone at high level must win over index 0 at low level (index 1 when the group is pin 0)
    for (int g = 0; g < 12; g++)
    begin
      s = src_of[g];
      o = (s == 0) ? 1 : 0;
      wr(`IPL_OFF_SEL_A, sel_of[g][7:0], `IPL_RESP_OKAY);
      wr(`IPL_OFF_SEL_B, sel_of[g][15:8], `IPL_RESP_OKAY);
      rd(`IPL_OFF_SEL_A, sel_of[g][7:0], `IPL_RESP_OKAY);
      src_req <= (33'h1 << s) | (33'h1 << o);
      idle(3);
      check({24'h0, taken}, {24'h0, 2'b11, s[5:0]});
      wr(`IPL_OFF_SEL_A, 8'h00, `IPL_RESP_OKAY);
      wr(`IPL_OFF_SEL_B, 8'h00, `IPL_RESP_OKAY);
      idle(3);
      check({24'h0, taken}, {24'h0, 2'b10, 6'((s < o) ? s : o)});
    end
    // reserved bits keep their value and move no group
    wr(`IPL_OFF_SEL_B, 8'h33, `IPL_RESP_OKAY);
    rd(`IPL_OFF_SEL_B, 8'h33, `IPL_RESP_OKAY);
    src_req <= 33'h011110004;
    idle(3);
    check({24'h0, taken}, {24'h0, 8'h82});
    // same requests, one level bit raised: the next arbitration follows it
    wr(`IPL_OFF_SEL_B, 8'h08, `IPL_RESP_OKAY);
    idle(3);
    check({24'h0, vld, lvl, idx}, {24'h0, 8'hd8});
    // status shows the presented request and ignores writes
    rd(`IPL_OFF_STATUS, 8'hd8, `IPL_RESP_OKAY);
    wr(`IPL_OFF_STATUS, 8'h00, `IPL_RESP_OKAY);
    rd(`IPL_OFF_STATUS, 8'hd8, `IPL_RESP_OKAY);
    // unmapped place refused, masked byte ignored
    wr(8'h0c, 8'hff, `IPL_RESP_SLVERR);
    rd(8'h0c, 8'h00, `IPL_RESP_SLVERR);
    wstrb <= 4'he;
    wr(`IPL_OFF_SEL_A, 8'hff, `IPL_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`IPL_OFF_SEL_A, 8'h00, `IPL_RESP_OKAY);
    // standby clears both registers
    wr(`IPL_OFF_SEL_A, 8'hff, `IPL_RESP_OKAY);
    @(posedge clock);
    hw_standby <= 1'b1;
    @(posedge clock);
    hw_standby <= 1'b0;
    rd(`IPL_OFF_SEL_A, 8'h00, `IPL_RESP_OKAY);
    rd(`IPL_OFF_SEL_B, 8'h00, `IPL_RESP_OKAY);
    // a reset in mid-run clears the registers again
    wr(`IPL_OFF_SEL_A, 8'h5a, `IPL_RESP_OKAY);
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    rd(`IPL_OFF_SEL_A, 8'h00, `IPL_RESP_OKAY);
    // watchdog and converter share one bit; the smaller vector wins
    src_req <= 33'h100000040;
    wr(`IPL_OFF_SEL_A, 8'h08, `IPL_RESP_OKAY);
    idle(3);
    check({24'h0, taken}, {24'h0, 8'hc6});
    stop_test();
  end
endmodule // testbench
`default_nettype wire
